// File: verilog/hbp_host_port.sv
// Processor-side bus port, address decode and reset handling
`timescale 1ns/10ps
module hbp_host_port #(
    parameter logic [2:0]  CS_PIN_MASK = 3'b000,  // Set bit makes that shared pin a select
    parameter logic [14:0] ROM_CARE    = 15'h0800,
    parameter logic [14:0] ROM_VALUE   = 15'h0800,
    parameter logic [14:0] RAM_CARE    = 15'h0F80,
    parameter logic [14:0] RAM_VALUE   = 15'h0000,
    parameter logic [14:0] IO_CARE     = 15'h0FF0,
    parameter logic [14:0] IO_VALUE    = 15'h0700
) (
    // Clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          resetn_in,
    // Host bus pins
    input  wire logic                          active_low_initialise_in,
    input  wire logic                          phase_two_in,
    input  wire logic                          read_not_write_in,
    input  wire logic [hbp_pkg::ADDR_W-1:0]    host_address_lines_in,
    input  wire logic [hbp_pkg::DATA_W-1:0]    host_data_lines_in,
    output logic      [hbp_pkg::DATA_W-1:0]    host_data_lines_out,
    output logic                               host_data_lines_oe_out,
    // Shared select or peripheral pins
    input  wire logic                          port_b_line_four_in,
    output logic                               port_b_line_four_out,
    output logic                               port_b_line_four_oe_out,
    input  wire logic                          port_b_line_five_in,
    output logic                               port_b_line_five_out,
    output logic                               port_b_line_five_oe_out,
    input  wire logic                          input_port_line_two_in,
    // Port C pins
    output logic      [hbp_pkg::DATA_W-1:0]    port_c_out,
    // Internal peripheral side
    input  wire logic [hbp_pkg::PB_SHARE_W-1:0] pb_drive_in,
    input  wire logic [hbp_pkg::PB_SHARE_W-1:0] pb_oe_in,
    output logic      [hbp_pkg::CS_W-1:0]      shared_io_out,
    input  wire logic [hbp_pkg::DATA_W-1:0]    port_c_data_in,
    input  wire logic [hbp_pkg::DATA_W-1:0]    rd_data_in,
    output hbp_pkg::hbp_sel_t                  sel_out,
    output logic      [hbp_pkg::MEM_OFS_W-1:0] mem_offset_out,
    output logic      [hbp_pkg::IO_REG_W-1:0]  io_reg_out,
    output logic                               wr_strobe_out,
    output logic      [hbp_pkg::DATA_W-1:0]    wr_data_out,
    output logic                               init_out
);
    import hbp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter checks
    if ((3'((ROM_CARE | RAM_CARE | IO_CARE) >> ADDR_W) & ~CS_PIN_MASK) != 3'b000) begin : g_bad_cs
        $error("Decode uses a shared pin that is not a chip select");
    end
    if (((ROM_VALUE & ~ROM_CARE) | (RAM_VALUE & ~RAM_CARE) | (IO_VALUE & ~IO_CARE)) != 15'h0000)
    begin : g_bad_val
        $error("Decode value has bits outside its care mask");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers
    hbp_state_t       r;
    hbp_state_t       next_r;
    logic [DEC_W-1:0] dec_vec;
    logic             any_sel;
    logic             phase_fall;
    logic             rd_cond;
    logic             wr_cond;
    hbp_sel_t         sel;

    // Per-bit require high, require low or ignore
    function automatic logic dec_match(input logic [DEC_W-1:0] v,
                                       input logic [DEC_W-1:0] care,
                                       input logic [DEC_W-1:0] val);
        return ((v ^ val) & care) == 15'h0000;
    endfunction

    // Address and selects form the decode vector
    always_comb begin
        dec_vec    = {r.s2.shared, r.s2.addr};
        sel.io     = dec_match(dec_vec, IO_CARE, IO_VALUE);
        sel.ram    = dec_match(dec_vec, RAM_CARE, RAM_VALUE) && !sel.io;
        sel.rom    = dec_match(dec_vec, ROM_CARE, ROM_VALUE) && !sel.io && !sel.ram;
        any_sel    = (sel.io || sel.ram || sel.rom) && !r.init;
        phase_fall = r.phase_prev && !r.s2.phase_two;
        rd_cond    = any_sel && r.s2.rw && r.s2.phase_two;
        wr_cond    = any_sel && !r.s2.rw && phase_fall;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_r              = r;
        next_r.s1.addr      = host_address_lines_in;
        next_r.s1.data      = host_data_lines_in;
        next_r.s1.shared    = {input_port_line_two_in, port_b_line_four_in, port_b_line_five_in};
        next_r.s1.rw        = read_not_write_in;
        next_r.s1.phase_two = phase_two_in;
        next_r.s1.init_n    = active_low_initialise_in;
        next_r.s2           = r.s1;
        next_r.phase_prev   = r.s2.phase_two;
        // Initialise level taken at each phase-two fall
        if (phase_fall) begin
            next_r.init = !r.s2.init_n;
        end
        // One-cycle write pulse
        next_r.wr_strobe = wr_cond;
        // Drive the data bus only in a selected read
        next_r.rd_oe   = rd_cond;
        next_r.rd_data = rd_cond ? rd_data_in : DATA_RESET;
        // Port C forced high during initialise
        next_r.port_c  = next_r.init ? PORT_C_RESET : port_c_data_in;
        if (next_r.init) begin
            next_r.wr_strobe = 1'b0;
            next_r.rd_oe     = 1'b0;
        end
        // Byte is taken only together with its strobe, so a write that meets an
        // initialise on the same fall leaves the last written byte untouched
        if (next_r.wr_strobe) begin
            next_r.wr_data = r.s2.data;
        end
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            r        <= '0;
            r.init   <= 1'b1;
            r.port_c <= PORT_C_RESET;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign host_data_lines_out    = r.rd_data;
    assign host_data_lines_oe_out = r.rd_oe;
    assign port_c_out             = r.port_c;
    assign sel_out                = any_sel ? sel : '0;
    assign mem_offset_out         = r.s2.addr[MEM_OFS_W-1:0];
    assign io_reg_out             = r.s2.addr[IO_REG_W-1:0];
    assign wr_strobe_out          = r.wr_strobe;
    assign wr_data_out            = r.wr_data;
    assign init_out               = r.init;

    // Select pins are cut from the peripheral and never driven
    assign shared_io_out           = r.s2.shared & ~CS_PIN_MASK;
    assign port_b_line_five_out    = pb_drive_in[0];
    assign port_b_line_four_out    = pb_drive_in[1];
    assign port_b_line_five_oe_out = pb_oe_in[0] && !CS_PIN_MASK[0] && !r.init;
    assign port_b_line_four_oe_out = pb_oe_in[1] && !CS_PIN_MASK[1] && !r.init;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_low_at_fall;
        phase_fall && !r.s2.init_n;
    endsequence
    sequence s_high_at_fall;
        phase_fall && r.s2.init_n;
    endsequence
    sequence s_write_fall;
        wr_cond && r.s2.init_n;
    endsequence

    drive_only_read_a: assert property (host_data_lines_oe_out |-> $past(rd_cond))
        else $error("Data bus driven outside a selected read");
    read_drives_a: assert property ((rd_cond && !r.init) |=> host_data_lines_oe_out)
        else $error("Selected read did not drive data");
    write_on_fall_a: assert property (wr_strobe_out |-> $past(wr_cond))
        else $error("Write strobe without a selected phase-two fall");
    write_data_a: assert property (wr_strobe_out |-> wr_data_out == $past(r.s2.data))
        else $error("Captured write byte differs from the bus");
    write_single_a: assert property (wr_strobe_out |=> !wr_strobe_out)
        else $error("Write strobe longer than one cycle");
    init_enter_a: assert property (s_low_at_fall |=> init_out ##1 !host_data_lines_oe_out)
        else $error("Initialise not taken at phase-two fall");
    init_leave_a: assert property (s_high_at_fall |=> !init_out)
        else $error("Initialise not released at phase-two fall");
    port_c_high_a: assert property (init_out |-> port_c_out == PORT_C_RESET)
        else $error("Port C not high during initialise");
    lines_float_a: assert property (init_out |-> !port_b_line_four_oe_out
                                      && !port_b_line_five_oe_out)
        else $error("Peripheral line driven during initialise");
    cs_pin_quiet_a: assert property ((CS_PIN_MASK[1] |-> !port_b_line_four_oe_out)
                                     and (CS_PIN_MASK[0] |-> !port_b_line_five_oe_out))
        else $error("Chip-select pin driven as output");
    io_index_a: assert property (sel_out.io
        |-> io_reg_out == $past(host_address_lines_in[IO_REG_W-1:0], 2))
        else $error("Register index does not follow address bits three to zero");
    one_select_a: assert property ($onehot0(sel_out))
        else $error("More than one function selected");

    // Write, read data and port value follow-through
    write_taken_a: assert property (s_write_fall |=> wr_strobe_out
        && wr_data_out == $past(r.s2.data))
        else $error("Selected write at phase-two fall gave no strobe");
    wr_hold_a: assert property ((!wr_strobe_out && $past(resetn_in))
        |-> $stable(wr_data_out))
        else $error("Write byte changed without a strobe");
    read_data_a: assert property (host_data_lines_oe_out
        |-> host_data_lines_out == $past(rd_data_in))
        else $error("Read byte differs from the selected source");
    idle_data_a: assert property (!host_data_lines_oe_out
        |-> host_data_lines_out == DATA_RESET)
        else $error("Data output not zero outside a read");
    port_c_follow_a: assert property (!init_out
        |-> port_c_out == $past(port_c_data_in))
        else $error("Port C does not follow its source outside initialise");
    init_hold_a: assert property (!phase_fall |=> $stable(init_out))
        else $error("Initialise changed away from a phase-two fall");
    // Runs outside the default disable so that reset itself is checked
    reset_clear_a: assert property (disable iff (1'b0) !resetn_in |=> init_out
        && !wr_strobe_out && !host_data_lines_oe_out
        && host_data_lines_out == DATA_RESET && port_c_out == PORT_C_RESET)
        else $error("Reset did not clear the port");

endmodule

// File: include/hbp_pkg.sv
// Constants and carrier types for the processor-side bus port and reset block
package hbp_pkg;

    localparam int ADDR_W     = 12;  // Host address width
    localparam int DATA_W     = 8;   // Host data width
    localparam int CS_W       = 3;   // Shared chip-select-capable pins
    localparam int DEC_W      = CS_W + ADDR_W;  // Decode vector {cs3,cs2,cs1,addr}
    localparam int IO_REG_W   = 4;   // Peripheral register index width
    localparam int MEM_OFS_W  = 11;  // Memory offset passed to the arrays
    localparam int PB_SHARE_W = 2;   // Port B lines four and five
    localparam int RESET_MIN_PERIODS = 4;  // Least low time of the initialise pin

    localparam logic [DATA_W-1:0] DATA_RESET   = 8'h00;
    localparam logic [DATA_W-1:0] PORT_C_RESET = 8'hFF;

    // Pin samples, one synchroniser stage
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [CS_W-1:0]   shared;   // {input_port_line_two, line_four, line_five}
        logic              rw;
        logic              phase_two;
        logic              init_n;
    } hbp_pins_t;

    // Function selects
    typedef struct packed {
        logic rom;
        logic ram;
        logic io;
    } hbp_sel_t;

    // Whole state of the port
    typedef struct packed {
        hbp_pins_t         s1;
        hbp_pins_t         s2;
        logic              phase_prev;
        logic              init;
        logic              wr_strobe;
        logic [DATA_W-1:0] wr_data;
        logic              rd_oe;
        logic [DATA_W-1:0] rd_data;
        logic [DATA_W-1:0] port_c;
    } hbp_state_t;

endpackage

// File: tb/hbp_cpu_model.sv
// Processor model that drives the host bus and the initialise pin
`timescale 1ns/10ps
module hbp_cpu_model (
    // Clock and device data drive
    input  wire logic        clk_in,
    input  wire logic        dev_oe_in,
    input  wire logic [7:0]  dev_data_in,
    // Bus pins
    output logic             init_n_out,
    output logic             phase_out,
    output logic             rw_out,
    output logic [11:0]      addr_out,
    output logic [7:0]       bus_out
);
    logic       cpu_oe;
    logic [7:0] cpu_d;
    logic [7:0] last;

    // Wire level; undriven bus shows the inverse of its last level
    always_comb bus_out = dev_oe_in ? dev_data_in : (cpu_oe ? cpu_d : ~last);
    always @(posedge clk_in) last <= bus_out;

    initial begin
        init_n_out = 1'b0;
        phase_out  = 1'b0;
        rw_out     = 1'b1;
        addr_out   = 12'h400;
        cpu_oe     = 1'b0;
        cpu_d      = 8'h00;
        last       = 8'h00;
    end

    // Free-running phase-two periods with the initialise pin held at one level
    task automatic phase_run(input int n, input logic lvl);
        init_n_out = lvl;
        repeat (n) begin
            phase_out = 1'b1;
            repeat (4) @(negedge clk_in);
            phase_out = 1'b0;
            repeat (4) @(negedge clk_in);
        end
    endtask

    // One bus cycle; address, direction and write data stand across phase two high
    task automatic bus_cycle(input logic [11:0] a, input logic r, input logic [7:0] d,
                             output logic [7:0] q, output logic drv);
        @(negedge clk_in);
        addr_out  = a;
        rw_out    = r;
        cpu_d     = d;
        cpu_oe    = !r;
        phase_out = 1'b1;
        repeat (6) @(negedge clk_in);
        q         = bus_out;
        drv       = dev_oe_in;
        phase_out = 1'b0;
        repeat (4) @(negedge clk_in);
        cpu_oe    = 1'b0;
        rw_out    = 1'b1;
        addr_out  = 12'h400;
    endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the host bus port and reset block
`timescale 1ns/10ps
module tb_top;
    import hbp_pkg::*;
    logic clk, resetn, pb4, pb5, l2, init_n, phase, rw, oe, wr_stb, init, pb4_oe, pb5_oe;
    logic [11:0] addr;
    logic [7:0]  bus, dout, rdd, wr_data, port_c, q;
    logic [3:0]  io_reg, last_io;
    logic [2:0]  shared;
    hbp_sel_t    sel;
    logic        drv, pb4_out, pb5_out;
    logic [10:0] mem_ofs;
    int          miscompares, samples_checked, strobes;

    hbp_host_port #(.CS_PIN_MASK(3'b001), .ROM_CARE(15'h1800), .ROM_VALUE(15'h1800)) uut (
        .clk_in(clk), .resetn_in(resetn), .active_low_initialise_in(init_n),
        .phase_two_in(phase), .read_not_write_in(rw), .host_address_lines_in(addr),
        .host_data_lines_in(bus), .host_data_lines_out(dout), .host_data_lines_oe_out(oe),
        .port_b_line_four_in(pb4), .port_b_line_four_out(pb4_out),
        .port_b_line_four_oe_out(pb4_oe), .port_b_line_five_in(pb5),
        .port_b_line_five_out(pb5_out), .port_b_line_five_oe_out(pb5_oe),
        .input_port_line_two_in(l2), .port_c_out(port_c), .pb_drive_in(2'h2),
        .pb_oe_in(2'h3), .shared_io_out(shared), .port_c_data_in(8'h5A), .rd_data_in(rdd),
        .sel_out(sel), .mem_offset_out(mem_ofs), .io_reg_out(io_reg), .wr_strobe_out(wr_stb),
        .wr_data_out(wr_data), .init_out(init));

    hbp_cpu_model cpu (.clk_in(clk), .dev_oe_in(oe), .dev_data_in(dout),
        .init_n_out(init_n), .phase_out(phase), .rw_out(rw), .addr_out(addr), .bus_out(bus));

    // Clock, strobe count and last selected register index
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wr_stb === 1'b1) strobes <= strobes + 1;
        if (sel.io === 1'b1) last_io <= io_reg;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Reset, then leave the initialise state
    task automatic t_reset();
        resetn = 1'b0;
        repeat (20) @(negedge clk);
        check({init, port_c, oe, pb4_oe, pb5_oe}, {1'b1, 8'hFF, 3'b000});
        resetn = 1'b1;
        cpu.phase_run(5, 1'b0);
        cpu.phase_run(2, 1'b1);
        check({init, port_c, pb4_oe, pb5_oe}, {1'b0, 8'h5A, 2'b10});
        check({pb4_out, pb5_out}, 2'b10);
        l2 = 1'b1;
        pb5 = 1'b1;
        repeat (3) @(negedge clk);
        check(shared, 3'b100);
    endtask

    // Selected reads drive the bus, deselected ones do not
    task automatic t_read();
        rdd = 8'h3C;
        cpu.bus_cycle(12'h9AB, 1'b1, 8'h00, q, drv);
        check({drv, q}, {1'b1, 8'h3C});
        check(dout, 8'h00);
        rdd = 8'hC3;
        cpu.bus_cycle(12'h705, 1'b1, 8'h00, q, drv);
        check({drv, q, last_io}, {1'b1, 8'hC3, 4'h5});
        pb5 = 1'b0;
        cpu.bus_cycle(12'h9AB, 1'b1, 8'h00, q, drv);
        check(drv, 1'b0);
    endtask

    // Selected write strobes once; unselected write is ignored
    task automatic t_write();
        strobes = 0;
        cpu.bus_cycle(12'h012, 1'b0, 8'hA5, q, drv);
        cpu.bus_cycle(12'h400, 1'b0, 8'h77, q, drv);
        repeat (2) @(negedge clk);
        check({drv, strobes[3:0], wr_data}, {1'b0, 4'h1, 8'hA5});
        check(mem_ofs, 11'h400);
    endtask

    // Initialise pin low in mid-run
    task automatic t_reinit();
        cpu.phase_run(4, 1'b0);
        check({init, port_c, pb4_oe}, {1'b1, 8'hFF, 1'b0});
        cpu.phase_run(2, 1'b1);
        check(init, 1'b0);
    endtask

    // Reset pulse in mid-run clears the port, then initialise is left again
    task automatic t_rst_mid();
        resetn = 1'b0;
        repeat (4) @(negedge clk);
        check({init, port_c, oe, wr_stb, dout}, {1'b1, 8'hFF, 2'b00, 8'h00});
        resetn = 1'b1;
        cpu.phase_run(2, 1'b1);
        check({init, port_c}, {1'b0, 8'h5A});
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_sim();
    end

    initial begin
        resetn = 1'b0;
        pb4 = 1'b0;
        pb5 = 1'b0;
        l2 = 1'b0;
        rdd = 8'h00;
        miscompares = 0;
        samples_checked = 0;
        strobes = 0;
        last_io = 4'h0;
        t_reset();
        t_read();
        t_write();
        t_reinit();
        t_rst_mid();
        end_sim();
    end
endmodule
